// ---- core/osc_trim_consts.svh ----
// Register offsets, reset values and timing counts for the oscillator trim block
`ifndef OSC_TRIM_CONSTS_SVH
`define OSC_TRIM_CONSTS_SVH
`define OFS_CRYSTAL_CAPACITOR_TRIM 12'h000
`define OFS_TRIM_CONTROL 12'h004
`define OFS_SYSTEM_STATUS 12'h008
`define OFS_FAST_RC_CONTROL 12'h00c
`define OFS_CLOCK_CONTROL 12'h010
`define OFS_REFERENCE_COUNT_TARGET 12'h014
`define OFS_REFERENCE_SELECT 12'h018
`define OFS_MEASURED_COUNT_LOW 12'h01c
`define OFS_MEASURED_COUNT_HIGH 12'h020
`define OFS_IRQ_STATUS 12'h024
`define OFS_IRQ_MASK 12'h028
`define RST_CRYSTAL_CAPACITOR_TRIM 11'h000
`define RST_TRIM_CONTROL 8'h00
`define RST_FAST_RC_TRIM 6'h00
`define TRIM_DELAY_POS 0
`define SETTLE_TIME_POS 4
`define SEL_RUN_BIT 2
`define SEL_SLOW_RC 3'h4
`define SEL_FAST_RC 3'h5
`define SEL_SLOW_XTAL 3'h6
`define SEL_ENH_RC 3'h7
`define CLK_FREQ_MHZ 250
`define INTERVAL_US 250
`define INTERVAL_CYCLES (`INTERVAL_US * `CLK_FREQ_MHZ)
`define IRQ_TRIM_BIT 0
`define IRQ_SETTLED_BIT 1
`define IRQ_CAL_DONE_BIT 2
`endif

// ---- core/osc_trim_pkg.sv ----
// Types shared by the oscillator trim block
package osc_trim_pkg;
    typedef enum logic [1:0] {
        XTAL_OFF,
        XTAL_TRIM_WAIT,
        XTAL_SETTLE_WAIT,
        XTAL_READY
    } xtal_state_t;
    typedef struct packed {
        logic [6:0] coarse;
        logic [7:0] fine;
    } cap_switch_t;
    typedef struct packed {
        logic ext_sleep_clk;
        logic sys_on_fast_rc;
        logic trim_applied;
        logic settled;
    } clk_status_t;
endpackage

// ---- core/osc_trim_and_calibration.sv ----
// Crystal trim sequencing, capacitor decode and reference counter
//
// Notes on behaviour
// - Trim zero gives smallest capacitance; all ones gives the largest.
// - One trim word moves both banks together over 2048 steps.
// - Low eight trim bits drive the binary fine switches directly.
// - Top three bits decode to a seven-wide thermometer; 000 and 001 alike.
// - Each thermometer output drives one coarse capacitor of 256 units.
// - After crystal enable, count 250 us periods, then apply trim and flag.
// - Zero trim delay applies the trim at once on crystal start.
// - After trim applied, count settle periods, then flag crystal settled.
// - Fast RC trim resets to its minimum value.
// - Fast RC clocks the system while crystal settles after wakeup.
// - Slow crystal has no trim and clocks the deep sleep modes.
// - Reference counter measures a chosen clock over N of its periods.
// - Select values 4 to 7 pick the measured clock and start a run.
// - Run bit stays one while measuring and clears when done.
// - Measured count is 32 bits, read as high and low halves.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "osc_trim_consts.svh"
module osc_trim_and_calibration (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slow_xtal_clk,
    input wire logic fast_rc_clk,
    input wire logic slow_rc_clk,
    input wire logic enh_rc_clk,
    output osc_trim_pkg::cap_switch_t cap_switch,
    output logic [5:0] fast_rc_trim,
    output osc_trim_pkg::clk_status_t clk_status,
    output logic irq
);
    function automatic logic [6:0] thermo(input logic [2:0] code);
        logic [6:0] t;
        t = 7'h01;
        for (int i = 1; i < 7; i++) begin
            if (code > 3'(i)) begin
                t[i] = 1'b1;
            end
        end
        return t;
    endfunction

    // Shared increments and address decode, each used in several places
    function automatic logic [3:0] step4(input logic [3:0] v);
        return v + 4'h1;
    endfunction

    function automatic logic [31:0] step32(input logic [31:0] v);
        return v + 32'h0000_0001;
    endfunction

    function automatic logic [11:0] word_addr(input logic [31:0] a);
        return {a[11:2], 2'b00};
    endfunction

    logic [10:0] crystal_capacitor_trim_reg;
    logic [7:0] trim_control_reg;
    logic [5:0] fast_rc_trim_reg;
    logic [1:0] clock_control_reg;
    logic [31:0] reference_count_target_reg;
    logic [2:0] reference_select_reg;
    logic [31:0] measured_count_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic bus_wr_reg;
    logic [11:0] bus_addr_reg;
    osc_trim_pkg::xtal_state_t xtal_state_reg;
    logic [15:0] tick_cnt_reg;
    logic [3:0] period_cnt_reg;
    logic [31:0] ref_cycles_reg;
    logic [31:0] ref_periods_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] meas_prev_reg;
    logic [31:0] rd_next;
    logic meas_sync;
    logic meas_rise;
    logic tick;
    logic xtal_en;
    logic trim_applied;
    logic cal_done;
    logic [3:0] trim_delay;
    logic [3:0] settle_time;
    logic [2:0] irq_set;
    logic status_rd;
    logic rd_take;
    logic xtal_ready;
    logic [2:0] irq_status_next;

    assign xtal_en = clock_control_reg[0];
    assign trim_delay = trim_control_reg[`TRIM_DELAY_POS +: 4];
    assign settle_time = trim_control_reg[`SETTLE_TIME_POS +: 4];
    assign xtal_ready = (xtal_state_reg == osc_trim_pkg::XTAL_READY);
    assign trim_applied = (xtal_state_reg == osc_trim_pkg::XTAL_SETTLE_WAIT) || xtal_ready;
    // Interval is fixed, so the longest trim delay waits close to 3.75 ms
    assign tick = (tick_cnt_reg == 16'(`INTERVAL_CYCLES - 1));
    assign meas_sync = sync2_reg[reference_select_reg[1:0]];
    // Per-source history, so switching sources cannot fake a rising edge
    assign meas_rise = meas_sync && !meas_prev_reg[reference_select_reg[1:0]];
    // A read is taken in its address phase; hrdata then stands in the data phase
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    // Clear on the edge that captures the read data, so no event is lost unread
    assign status_rd = rd_take && (word_addr(haddr) == `OFS_IRQ_STATUS);
    assign irq_status_next = (status_rd ? 3'h0 : irq_status_reg) | irq_set;

    // Bus address phase capture; zero wait states, always OKAY
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus_wr_reg <= 1'b0;
            bus_addr_reg <= 12'h000;
        end else if (clk_en) begin
            bus_wr_reg <= hsel && hready && htrans[1] && hwrite;
            bus_addr_reg <= word_addr(haddr);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read mux registered from address phase so hrdata comes from a flop
    always_comb begin
        rd_next = 32'h0000_0000;
        case (word_addr(haddr))
            `OFS_CRYSTAL_CAPACITOR_TRIM: rd_next = {21'h0, crystal_capacitor_trim_reg};
            `OFS_TRIM_CONTROL: rd_next = {24'h0, trim_control_reg};
            `OFS_SYSTEM_STATUS: rd_next = {28'h0, clk_status};
            `OFS_FAST_RC_CONTROL: rd_next = {26'h0, fast_rc_trim_reg};
            `OFS_CLOCK_CONTROL: rd_next = {30'h0, clock_control_reg};
            `OFS_REFERENCE_COUNT_TARGET: rd_next = reference_count_target_reg;
            `OFS_REFERENCE_SELECT: rd_next = {29'h0, reference_select_reg};
            `OFS_MEASURED_COUNT_LOW: rd_next = {16'h0, measured_count_reg[15:0]};
            `OFS_MEASURED_COUNT_HIGH: rd_next = {16'h0, measured_count_reg[31:16]};
            `OFS_IRQ_STATUS: rd_next = {29'h0, irq_status_reg};
            `OFS_IRQ_MASK: rd_next = {29'h0, irq_mask_reg};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && rd_take) begin
            hrdata <= rd_next;
        end
    end

    // Software-written configuration
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            crystal_capacitor_trim_reg <= `RST_CRYSTAL_CAPACITOR_TRIM;
            trim_control_reg <= `RST_TRIM_CONTROL;
            fast_rc_trim_reg <= `RST_FAST_RC_TRIM;
            clock_control_reg <= 2'h0;
            reference_count_target_reg <= 32'h0000_0000;
            irq_mask_reg <= 3'h0;
        end else if (clk_en && bus_wr_reg) begin
            case (bus_addr_reg)
                `OFS_CRYSTAL_CAPACITOR_TRIM: crystal_capacitor_trim_reg <= hwdata[10:0];
                `OFS_TRIM_CONTROL: trim_control_reg <= hwdata[7:0];
                `OFS_FAST_RC_CONTROL: fast_rc_trim_reg <= hwdata[5:0];
                `OFS_CLOCK_CONTROL: clock_control_reg <= hwdata[1:0];
                `OFS_REFERENCE_COUNT_TARGET: reference_count_target_reg <= hwdata;
                `OFS_IRQ_MASK: irq_mask_reg <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // 250 us interval timer, held clear while the crystal is off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= 16'h0000;
        end else if (clk_en) begin
            if (!xtal_en || tick) begin
                tick_cnt_reg <= 16'h0000;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            end
        end
    end

    // Crystal start sequence: trim delay, then settle delay
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_state_reg <= osc_trim_pkg::XTAL_OFF;
            period_cnt_reg <= 4'h0;
        end else if (clk_en) begin
            if (!xtal_en) begin
                xtal_state_reg <= osc_trim_pkg::XTAL_OFF;
                period_cnt_reg <= 4'h0;
            end else begin
                case (xtal_state_reg)
                    osc_trim_pkg::XTAL_OFF: begin
                        period_cnt_reg <= 4'h0;
                        if (trim_delay == 4'h0) begin
                            xtal_state_reg <= osc_trim_pkg::XTAL_SETTLE_WAIT;
                        end else begin
                            xtal_state_reg <= osc_trim_pkg::XTAL_TRIM_WAIT;
                        end
                    end
                    osc_trim_pkg::XTAL_TRIM_WAIT: begin
                        if (tick) begin
                            if (step4(period_cnt_reg) >= trim_delay) begin
                                xtal_state_reg <= osc_trim_pkg::XTAL_SETTLE_WAIT;
                                period_cnt_reg <= 4'h0;
                            end else begin
                                period_cnt_reg <= step4(period_cnt_reg);
                            end
                        end
                    end
                    osc_trim_pkg::XTAL_SETTLE_WAIT: begin
                        if (settle_time == 4'h0) begin
                            xtal_state_reg <= osc_trim_pkg::XTAL_READY;
                        end else if (tick) begin
                            if (step4(period_cnt_reg) >= settle_time) begin
                                xtal_state_reg <= osc_trim_pkg::XTAL_READY;
                            end else begin
                                period_cnt_reg <= step4(period_cnt_reg);
                            end
                        end
                    end
                    osc_trim_pkg::XTAL_READY: period_cnt_reg <= 4'h0;
                    default: xtal_state_reg <= osc_trim_pkg::XTAL_OFF;
                endcase
            end
        end
    end

    // Capacitor switches; until trim applies the banks sit at code zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cap_switch <= '{coarse: 7'h01, fine: 8'h00};
        end else if (clk_en) begin
            if (trim_applied) begin
                cap_switch.fine <= crystal_capacitor_trim_reg[7:0];
                cap_switch.coarse <= thermo(crystal_capacitor_trim_reg[10:8]);
            end else begin
                cap_switch <= '{coarse: 7'h01, fine: 8'h00};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fast_rc_trim <= `RST_FAST_RC_TRIM;
            clk_status <= '0;
        end else if (clk_en) begin
            fast_rc_trim <= fast_rc_trim_reg;
            clk_status.trim_applied <= trim_applied;
            clk_status.settled <= xtal_ready;
            // Fast RC runs the system until the crystal is usable
            clk_status.sys_on_fast_rc <= !xtal_ready;
            clk_status.ext_sleep_clk <= clock_control_reg[1];
        end
    end

    // Measured clocks are asynchronous: two flops before any use
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            meas_prev_reg <= 4'h0;
        end else if (clk_en) begin
            sync1_reg <= {enh_rc_clk, slow_xtal_clk, fast_rc_clk, slow_rc_clk};
            sync2_reg <= sync1_reg;
            meas_prev_reg <= sync2_reg;
        end
    end

    // Reference counter; fast RC near 16 MHz is well under half this clock
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reference_select_reg <= 3'h0;
            ref_cycles_reg <= 32'h0000_0000;
            ref_periods_reg <= 32'h0000_0000;
            measured_count_reg <= 32'h0000_0000;
            cal_done <= 1'b0;
        end else if (clk_en) begin
            cal_done <= 1'b0;
            if (bus_wr_reg && bus_addr_reg == `OFS_REFERENCE_SELECT && hwdata[`SEL_RUN_BIT]) begin
                reference_select_reg <= hwdata[2:0];
                ref_cycles_reg <= 32'h0000_0000;
                ref_periods_reg <= 32'h0000_0000;
            end else if (reference_select_reg[`SEL_RUN_BIT]) begin
                ref_cycles_reg <= step32(ref_cycles_reg);
                if (meas_rise) begin
                    if (step32(ref_periods_reg) >= reference_count_target_reg) begin
                        reference_select_reg[`SEL_RUN_BIT] <= 1'b0;
                        measured_count_reg <= step32(ref_cycles_reg);
                        cal_done <= 1'b1;
                    end else begin
                        ref_periods_reg <= step32(ref_periods_reg);
                    end
                end
            end
        end
    end

    assign irq_set[`IRQ_TRIM_BIT] = trim_applied && !clk_status.trim_applied;
    assign irq_set[`IRQ_SETTLED_BIT] =
        xtal_ready && !clk_status.settled;
    assign irq_set[`IRQ_CAL_DONE_BIT] = cal_done;

    // Read clears; a new event in the same cycle wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status_reg <= 3'h0;
        end else if (clk_en) begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Built from the next status so the level never lags the sticky bits
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end
endmodule

// ---- tb/osc_trim_properties.sv ----
// Port-level checker for the oscillator trim block
`timescale 1ns/10ps
module osc_trim_properties (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire osc_trim_pkg::cap_switch_t cap_switch,
    input wire logic [5:0] fast_rc_trim,
    input wire osc_trim_pkg::clk_status_t clk_status,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Thermometer: bit 0 always set, no holes above
    a_coarse_thermometer: assert property (
        cap_switch.coarse[0] && ((cap_switch.coarse & (cap_switch.coarse + 7'h01)) == 7'h00))
        else $error("coarse switches not thermometer coded");
    // One quiet cycle guards the lag after a disable
    a_code_zero_idle: assert property (
        !clk_status.trim_applied && !$past(clk_status.trim_applied) |-> cap_switch == 15'h0100)
        else $error("switches not at code zero before trim applied");
    a_settled_needs_trim: assert property (clk_status.settled |-> clk_status.trim_applied)
        else $error("settled without trim applied");
    a_settle_after_trim: assert property (
        $rose(clk_status.settled) |-> $past(clk_status.trim_applied))
        else $error("settled rose before trim applied");
    a_flags_drop_together: assert property (
        $fell(clk_status.trim_applied) |-> !clk_status.settled)
        else $error("settled left standing after crystal stop");
    a_rc_trim_minimum: assert property ($rose(resetn) |-> fast_rc_trim == 6'h00)
        else $error("fast rc trim not minimum after reset");
    a_bus_ready: assert property (hreadyout ##1 hreadyout)
        else $error("bus wait state inserted");
    a_bus_okay: assert property (!hresp ##1 !hresp)
        else $error("bus error response");
    c_trim: cover property ($rose(clk_status.trim_applied));
    c_settle: cover property ($rose(clk_status.settled));
    c_irq: cover property ($rose(irq));
endmodule
bind osc_trim_and_calibration osc_trim_properties u_props (.sys_clk(sys_clk), .resetn(resetn),
    .hreadyout(hreadyout), .hresp(hresp), .cap_switch(cap_switch),
    .fast_rc_trim(fast_rc_trim), .clk_status(clk_status), .irq(irq));

// ---- tb/osc_trim_and_calibration_tb.sv ----
// Self-checking bench for the oscillator trim block
`timescale 1ns/10ps
`include "osc_trim_consts.svh"
module osc_trim_and_calibration_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic slow_xtal_clk = 1'b0;
    logic fast_rc_clk = 1'b0;
    logic slow_rc_clk = 1'b0;
    logic enh_rc_clk = 1'b0;
    osc_trim_pkg::cap_switch_t cap_switch;
    logic [5:0] fast_rc_trim;
    osc_trim_pkg::clk_status_t clk_status;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] q;
    always #2 sys_clk = ~sys_clk;
    // Measured clocks free-run at unrelated periods: 40, 24, 56, 48 ns
    always #20 slow_rc_clk = ~slow_rc_clk;
    always #12 fast_rc_clk = ~fast_rc_clk;
    always #28 slow_xtal_clk = ~slow_xtal_clk;
    always #24 enh_rc_clk = ~enh_rc_clk;
    osc_trim_and_calibration dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .slow_xtal_clk(slow_xtal_clk), .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk),
        .enh_rc_clk(enh_rc_clk), .cap_switch(cap_switch), .fast_rc_trim(fast_rc_trim),
        .clk_status(clk_status), .irq(irq));
    task tally_and_finish;
        $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One long crystal delay of 62500 cycles dominates the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_total++;
            $display("unexpected at %0t: run timed out", $time);
            tally_and_finish;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Entered just after a rising edge; hreadyout is waited on, never assumed
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task t_reset;
        chk(fast_rc_trim, 32'h0, "rc trim");
        chk(cap_switch, 32'h100, "idle switches");
        rd(`OFS_CRYSTAL_CAPACITOR_TRIM);
        chk(q, 32'h0, "trim reset");
        wr(`OFS_SYSTEM_STATUS, 32'hf);
        rd(`OFS_SYSTEM_STATUS);
        chk(q, 32'h4, "status");
        rd(12'h03c);
        chk(q, 32'h0, "unmapped");
        wr(`OFS_FAST_RC_CONTROL, 32'h2a);
        repeat (2) @(posedge sys_clk);
        chk(fast_rc_trim, 32'h2a, "rc trim write");
        rd(`OFS_FAST_RC_CONTROL);
        chk(q, 32'h2a, "rc trim readback");
        $display("test reset done");
    endtask
    task t_decode;
        logic [7:0] fine;
        wr(`OFS_TRIM_CONTROL, 32'h0);
        wr(`OFS_CLOCK_CONTROL, 32'h1);
        repeat (4) @(posedge sys_clk);
        chk(clk_status.trim_applied, 1, "immediate trim");
        chk(clk_status.settled, 1, "zero settle");
        for (int c = 0; c < 8; c++) begin
            fine = (c == 7) ? 8'hff : 8'(c * 17);
            wr(`OFS_CRYSTAL_CAPACITOR_TRIM, {21'h0, 3'(c), fine});
            repeat (3) @(posedge sys_clk);
            chk(cap_switch.coarse, (c < 2) ? 32'h1 : (32'h1 << c) - 32'h1, "coarse");
            chk(cap_switch.fine, fine, "fine");
        end
        rd(`OFS_CRYSTAL_CAPACITOR_TRIM);
        chk(q, 32'h7ff, "trim readback");
        wr(`OFS_CLOCK_CONTROL, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk({clk_status.trim_applied, clk_status.settled}, 0, "flags cleared");
        chk(cap_switch, 32'h100, "switches idle");
        chk(clk_status.ext_sleep_clk, 1, "sleep clock");
        chk(irq, 0, "masked irq");
        rd(`OFS_IRQ_STATUS);
        chk(q[1:0], 2'b11, "sticky events");
        $display("test decode done");
    endtask
    task t_delay;
        wr(`OFS_IRQ_MASK, 32'h3);
        wr(`OFS_TRIM_CONTROL, 32'h1);
        wr(`OFS_CLOCK_CONTROL, 32'h1);
        repeat (62000) @(posedge sys_clk);
        chk(clk_status.trim_applied, 0, "early trim");
        chk(irq, 0, "early irq");
        for (int i = 0; i < 1000 && clk_status.trim_applied !== 1'b1; i++) @(posedge sys_clk);
        chk(clk_status.trim_applied, 1, "delayed trim");
        repeat (3) @(posedge sys_clk);
        chk(clk_status.settled, 1, "settled");
        chk(irq, 1, "irq raised");
        rd(`OFS_IRQ_STATUS);
        chk(q[2:0], 3'b011, "irq status");
        repeat (2) @(posedge sys_clk);
        chk(irq, 0, "irq cleared");
        wr(`OFS_CLOCK_CONTROL, 32'h0);
        $display("test delay done");
    endtask
    task t_cal;
        int p;
        logic [31:0] m;
        for (int s = 4; s < 8; s++) begin
            p = (s == 4) ? 40 : (s == 5) ? 24 : (s == 6) ? 56 : 48;
            wr(`OFS_IRQ_MASK, (s == 4) ? 32'h0 : 32'h4);
            wr(`OFS_REFERENCE_COUNT_TARGET, 32'h3);
            wr(`OFS_REFERENCE_SELECT, 32'(s));
            rd(`OFS_REFERENCE_SELECT);
            chk(q[2], 1, "run bit set");
            for (int i = 0; i < 200 && q[2] !== 1'b0; i++) rd(`OFS_REFERENCE_SELECT);
            chk(q[2], 0, "run bit clear");
            chk(irq, s != 4, "cal irq");
            rd(`OFS_MEASURED_COUNT_LOW);
            m = q;
            rd(`OFS_MEASURED_COUNT_HIGH);
            chk(q, 32'h0, "count high");
            // Start phase is free, so allow one period plus sync latency
            chk(m >= 2 * p / 4 && m <= 3 * p / 4 + 8, 1, "count range");
            rd(`OFS_IRQ_STATUS);
            chk(q[2], 1, "cal done event");
        end
        $display("test calibration done");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_decode;
        t_delay;
        t_cal;
        tally_and_finish;
    end
endmodule
